/* include/sdram_cmd_pkg.sv */
package sdram_cmd_pkg;

  // Array geometry and pin widths
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;

  // Address bit that carries the precharge flag
  localparam int AP_BIT = 10;

  // Mode register field positions and reset values
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h030;
  localparam logic [ADDR_W-1:0] EXT_RST = 12'h000;

  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Read latency code for two clocks; any other code gives three
  localparam logic [2:0] CL_2 = 3'h2;

  // Bank select values during a mode load
  localparam logic [BANK_W-1:0] MR_SEL_BASE = 2'h0;
  localparam logic [BANK_W-1:0] MR_SEL_EXT = 2'h2;

  // Commands as {row_strobe_n, column_strobe_n, write_strobe_n}
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef enum logic [2:0] {
    PS_RUN,
    PS_PRE_PD,
    PS_ACT_PD,
    PS_SUSPEND,
    PS_SELF_REF,
    PS_DEEP_PD
  } power_state_t;

endpackage

/* core/bank_row_tracker.sv */
`timescale 1ns/1ps
`default_nettype none

module bank_row_tracker
  import sdram_cmd_pkg::*;
#(
  parameter int ROW_BITS = ROW_W
)(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic open_req, // Activate this bank
  input wire logic close_req, // Precharge this bank
  input wire logic [ROW_BITS-1:0] row_in, // Row to open
  output logic open_q, // Row is open
  output logic [ROW_BITS-1:0] row_q // Open row
);

  // Each bank keeps its own row, so one can close while another streams
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      open_q <= 1'b0;
      row_q <= '0;
    end
    else if (open_req)
    begin
      open_q <= 1'b1;
      row_q <= row_in;
    end
    else if (close_req)
    begin
      open_q <= 1'b0;
    end
  end

endmodule // bank_row_tracker

`default_nettype wire

/* core/sdram_command_interface.sv */
// What this block does
// R1 - Every input is captured only on the rising clock edge.
// R2 - Four banks, each 4096 rows by 512 columns of 16-bit words.
// R3 - Controller opens a row with ACTIVE before reading or writing that bank.
// R4 - ACTIVE takes bank from bank_select and row from the twelve address inputs.
// R5 - READ or WRITE address is the first column; a counter supplies later ones.
// R6 - Bursts of 1, 2, 4, 8 or full page; terminate ends a burst early.
// R7 - Auto precharge closes the row by itself once the burst completes.
// R8 - A new column address is accepted on every clock cycle.
// R9 - One bank may precharge while another bank is accessed.
// R10 - Each enabled edge advances the burst counter and clocks output registers.
// R11 - clock_gate_in high runs the internal clock; low stops it.
// R12 - Clock gate low picks power-down, self refresh, deep power-down or suspend.
// R13 - In power-down or self refresh the clock gate is asynchronous until exit; the code still samples it on the rising edge.
// R14 - Input buffers, clock included, are off during power-down and self refresh.
// R15 - Commands decode only with select_n low; high ignores every command.
// R16 - Strobes and select_n together encode the command, decoded each rising edge.
// R17 - Masked bytes of a write burst are discarded, leaving the array unchanged.
// R18 - Mask high during a read turns that byte to high impedance two clocks later.
// R19 - low_byte_mask covers data bits 0-7, high_byte_mask bits 8-15.
// R20 - Controller may hold clock_gate_in high if it never uses low-power modes.
// R21 - Address bit 10 with READ or WRITE requests auto precharge.
// R22 - PRECHARGE with bit 10 high closes all banks, else only the selected bank.
// R23 - During a mode load, bank_select picks mode or extended mode register.
// R24 - Controller waits 100 us issuing only inhibit or no-operation after power-up.
// R25 - Write mask applies to the data word on the same edge.
`timescale 1ns/1ps
`default_nettype none

module sdram_command_interface
  import sdram_cmd_pkg::*;
#(
  parameter int ROW_BITS = ROW_W,
  parameter int COL_BITS = COL_W
)(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic clock_gate_in, // Clock enable
  input wire logic select_n, // Chip select
  input wire logic row_strobe_n, // Row strobe
  input wire logic column_strobe_n, // Column strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic [BANK_W-1:0] bank_select, // Bank address
  input wire logic [ADDR_W-1:0] row_column_address, // Row, column or opcode
  input wire logic low_byte_mask, // Mask for bits 7:0
  input wire logic high_byte_mask, // Mask for bits 15:8
  input wire logic [DATA_W-1:0] dq_in, // Data pin input
  output logic [DATA_W-1:0] dq_out, // Data pin output
  output logic [1:0] dq_oe, // Per-byte output enable
  output logic [ADDR_W-1:0] ext_mode, // Extended mode register
  output power_state_t power_state // Low-power state
);

  localparam int BANKS = 1 << BANK_W;
  localparam int MEM_AW = BANK_W + ROW_BITS + COL_BITS;

  logic en;
  logic [2:0] cmd;
  logic live;
  logic do_act, do_rd, do_wr, do_pre, do_bst, do_lmr, do_rw;
  logic [ADDR_W-1:0] mode_q;
  logic [2:0] bl;
  logic page;
  logic [COL_BITS-1:0] rem0;
  logic burst_q, wr_q, ap_q, page_q;
  logic [BANK_W-1:0] bank_q;
  logic [COL_BITS-1:0] col_q, rem_q;
  logic stop, beat, cur_wr;
  logic [COL_BITS-1:0] cur_col;
  logic [BANK_W-1:0] cur_bank;
  logic ap_old, ap_new;
  logic [BANKS-1:0] open_v, close_v, act_v;
  logic [ROW_BITS-1:0] row_v [BANKS];
  logic [MEM_AW-1:0] widx;
  logic [DATA_W-1:0] mem [0:(1 << MEM_AW)-1]; // R2
  logic [DATA_W-1:0] word_now;
  logic [DATA_W-1:0] s1_q, s2_q;
  logic v1_q, v2_q;
  logic [1:0] m1_q;
  logic cke_q;

  // Burst length minus one for fixed lengths
  function automatic logic [COL_BITS-1:0] burst_rem(input logic [2:0] code);
    logic [COL_BITS-1:0] r;
    r = '0;
    case (code)
      BL_2: r = COL_BITS'(1);
      BL_4: r = COL_BITS'(3);
      BL_8: r = COL_BITS'(7);
      default: r = '0;
    endcase
    return r;
  endfunction

  // Next column wraps inside the burst window; full page wraps the row
  function automatic logic [COL_BITS-1:0] next_col(input logic [COL_BITS-1:0] c,
                                                   input logic [COL_BITS-1:0] m);
    logic [COL_BITS-1:0] inc;
    inc = c + COL_BITS'(1);
    return (c & ~m) | (inc & m);
  endfunction

  // Clock gate stops everything clocked below except the power-state logic; outputs freeze in suspend
  assign en = clock_gate_in; // R11
  assign cmd = {row_strobe_n, column_strobe_n, write_strobe_n}; // R16
  // Decoder is dead while deselected, gated, or in any low-power state
  assign live = en && (power_state == PS_RUN) && !select_n; // R15 R14
  assign do_act = live && (cmd == CMD_ACT);
  assign do_rd = live && (cmd == CMD_RD);
  assign do_wr = live && (cmd == CMD_WR);
  assign do_pre = live && (cmd == CMD_PRE);
  assign do_bst = live && (cmd == CMD_BST);
  assign do_lmr = live && (cmd == CMD_LMR);
  assign do_rw = do_rd || do_wr;

  assign bl = mode_q[MR_BL_LSB +: 3];
  assign page = (bl == BL_PAGE); // R6
  assign rem0 = burst_rem(bl); // R6

  // Terminate, or precharge of the burst's bank, cuts the burst short
  assign stop = do_bst || (do_pre && (row_column_address[AP_BIT] || bank_select == bank_q)); // R6
  // A new column command overrides the running burst at once
  assign beat = en && (do_rw || (burst_q && !stop)); // R8
  assign cur_col = do_rw ? row_column_address[COL_BITS-1:0] : col_q; // R5
  assign cur_bank = do_rw ? bank_select : bank_q;
  assign cur_wr = do_rw ? do_wr : wr_q;

  // Self-timed close: at the last word, or when a new access interrupts
  assign ap_old = en && burst_q && ap_q && (do_rw || (!stop && rem_q == COL_BITS'(1))); // R7
  assign ap_new = do_rw && row_column_address[AP_BIT] && !page && (rem0 == '0); // R21 R7

  // One tracker per bank lets precharge overlap another bank's traffic
  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      assign act_v[b] = do_act && (bank_select == BANK_W'(b)); // R4
      assign close_v[b] = (do_pre && (row_column_address[AP_BIT] ||
                          bank_select == BANK_W'(b))) // R22
                          || (ap_old && bank_q == BANK_W'(b))
                          || (ap_new && bank_select == BANK_W'(b)); // R9
      bank_row_tracker #(
        .ROW_BITS(ROW_BITS)
      ) u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .open_req(act_v[b]),
        .close_req(close_v[b]),
        .row_in(row_column_address[ROW_BITS-1:0]),
        .open_q(open_v[b]),
        .row_q(row_v[b])
      );
    end
  endgenerate

  // Row comes from the bank's tracker; controller must have opened it
  assign widx = {cur_bank, row_v[cur_bank], cur_col}; // R3
  assign word_now = mem[widx];

  // Mode registers; bank_select picks which one a load hits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RST;
      ext_mode <= EXT_RST;
    end
    else if (do_lmr)
    begin
      if (bank_select == MR_SEL_BASE) // R23
        mode_q <= row_column_address;
      else if (bank_select == MR_SEL_EXT) // R23
        ext_mode <= row_column_address;
    end
  end

  // Burst column counter and bookkeeping
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      burst_q <= 1'b0;
      wr_q <= 1'b0;
      ap_q <= 1'b0;
      page_q <= 1'b0;
      bank_q <= '0;
      col_q <= '0;
      rem_q <= '0;
    end
    else if (en) // R10
    begin
      if (do_rw) // R8
      begin
        burst_q <= page || (rem0 != '0);
        wr_q <= do_wr;
        ap_q <= row_column_address[AP_BIT] && !page; // R21
        page_q <= page;
        bank_q <= bank_select;
        col_q <= next_col(row_column_address[COL_BITS-1:0], page ? '1 : rem0); // R5
        rem_q <= rem0;
      end
      else if (burst_q)
      begin
        if (stop)
          burst_q <= 1'b0; // R6
        else
        begin
          col_q <= next_col(col_q, page_q ? '1 : burst_rem(bl)); // R10
          if (!page_q)
          begin
            rem_q <= rem_q - COL_BITS'(1);
            if (rem_q == COL_BITS'(1))
              burst_q <= 1'b0;
          end
        end
      end
    end
  end

  // Array writes; each byte lane obeys its own mask on the same edge
  always_ff @(posedge clk)
  begin
    if (beat && cur_wr)
    begin
      if (!low_byte_mask) // R17 R19 R25
        mem[widx][BYTE_W-1:0] <= dq_in[BYTE_W-1:0]; // R1
      if (!high_byte_mask) // R17 R19 R25
        mem[widx][DATA_W-1:BYTE_W] <= dq_in[DATA_W-1:BYTE_W];
    end
  end

  // Read pipeline; two stages cover both latency settings
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      m1_q <= '0;
      dq_out <= '0;
      dq_oe <= '0;
    end
    else if (en) // R10
    begin
      s1_q <= word_now;
      v1_q <= beat && !cur_wr;
      s2_q <= s1_q;
      v2_q <= v1_q;
      m1_q <= {high_byte_mask, low_byte_mask}; // R1
      dq_out <= (mode_q[MR_CL_LSB +: 3] == CL_2) ? s1_q : s2_q;
      // Mask reaches the pins two edges after sampling whatever the latency
      dq_oe <= {2{(mode_q[MR_CL_LSB +: 3] == CL_2) ? v1_q : v2_q}} & ~m1_q; // R18 R19
    end
  end

  // Falling clock gate chooses the low-power state from what is busy.
  // Inputs are only sampled here, so exit is seen one edge late at worst.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cke_q <= 1'b1;
      power_state <= PS_RUN;
    end
    else
    begin
      cke_q <= clock_gate_in;
      case (power_state)
        PS_RUN:
        begin
          if (cke_q && !clock_gate_in) // R12
          begin
            if (burst_q)
              power_state <= PS_SUSPEND;
            else if (!select_n && cmd == CMD_REF && open_v == '0)
              power_state <= PS_SELF_REF;
            else if (!select_n && cmd == CMD_BST && open_v == '0)
              power_state <= PS_DEEP_PD;
            else if (open_v != '0)
              power_state <= PS_ACT_PD;
            else
              power_state <= PS_PRE_PD;
          end
        end
        default:
        begin
          if (clock_gate_in) // R13
            power_state <= PS_RUN;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence rd4_start;
    en && do_rw && bl == BL_4;
  endsequence

  sequence quiet;
    en && !do_rw && !stop;
  endsequence

  a_deselect_no_open: assert property ( // R15
    select_n |=> (open_v & ~$past(open_v)) == '0)
    else $error("bank opened while deselected");

  a_activate_row: assert property ( // R4
    do_act |=> open_v[$past(bank_select)] &&
      row_v[$past(bank_select)] == $past(row_column_address))
    else $error("activate did not open the addressed row");

  a_precharge_all: assert property ( // R22
    do_pre && row_column_address[AP_BIT] |=> open_v == '0)
    else $error("precharge all left a bank open");

  a_write_mask_low: assert property ( // R17
    beat && cur_wr && low_byte_mask |=>
      mem[$past(widx)][BYTE_W-1:0] == $past(word_now[BYTE_W-1:0]))
    else $error("masked low byte was written");

  a_read_mask_hiz: assert property ( // R18
    (low_byte_mask && en) ##1 en |=> !dq_oe[0])
    else $error("masked read byte still driven");

  a_burst_four: assert property ( // R6
    rd4_start ##1 quiet [*3] |=> !burst_q)
    else $error("four-word burst length wrong");

  a_clock_stop: assert property ( // R11
    !clock_gate_in |=> $stable(col_q) && $stable(dq_out) && $stable(dq_oe))
    else $error("state moved with clock stopped");

  a_pd_entry: assert property ( // R12
    power_state == PS_RUN && cke_q && !clock_gate_in && !burst_q &&
      open_v == '0 && (select_n || cmd == CMD_NOP) |=> power_state == PS_PRE_PD)
    else $error("idle power-down not entered");

  a_ap_close: assert property ( // R7
    do_rw && row_column_address[AP_BIT] && bl == BL_1 |=> !open_v[$past(bank_select)])
    else $error("auto precharge left row open");

endmodule // sdram_command_interface

`default_nettype wire

/* dv/sdram_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdram_ctrl_model
  import sdram_cmd_pkg::*;
(
  input wire logic clk, // System clock
  output logic clock_gate_in, // Clock enable
  output logic select_n, // Chip select
  output logic row_strobe_n, // Row strobe
  output logic column_strobe_n, // Column strobe
  output logic write_strobe_n, // Write strobe
  output logic [BANK_W-1:0] bank_select, // Bank address
  output logic [ADDR_W-1:0] row_column_address, // Address
  output logic low_byte_mask, // Low byte mask
  output logic high_byte_mask, // High byte mask
  output logic [DATA_W-1:0] dq_in // Write data
);
  logic drop_sel = 1'b0; // Bench sets it to send a deselected command

  // Gate stays high except in the power tests
  initial
  begin
    clock_gate_in = 1'b1;
    select_n = 1'b1;
    {row_strobe_n, column_strobe_n, write_strobe_n} = CMD_NOP;
    bank_select = 2'h0;
    row_column_address = 12'h000;
    {high_byte_mask, low_byte_mask} = 2'b00;
    dq_in = 16'h0000;
  end

  // One command cycle, launched at the falling edge
  task automatic cmd(input logic [2:0] code, input logic [BANK_W-1:0] ba,
                     input logic [ADDR_W-1:0] a, input logic [1:0] msk,
                     input logic [DATA_W-1:0] d);
    @(negedge clk);
    select_n = drop_sel;
    {row_strobe_n, column_strobe_n, write_strobe_n} = code;
    bank_select = ba;
    row_column_address = a;
    {high_byte_mask, low_byte_mask} = msk;
    dq_in = d;
  endtask

  // First gated cycle; a selected code here picks self refresh or deep power-down
  task automatic gate_cmd(input logic [2:0] code);
    @(negedge clk);
    clock_gate_in = 1'b0;
    select_n = (code == CMD_NOP);
    {row_strobe_n, column_strobe_n, write_strobe_n} = code;
    {high_byte_mask, low_byte_mask} = 2'b00;
  endtask

  // Deselected cycles; released data toggles so no stale word looks valid
  task automatic idle(input int n, input logic gate);
    repeat (n)
    begin
      @(negedge clk);
      clock_gate_in = gate;
      select_n = 1'b1;
      {row_strobe_n, column_strobe_n, write_strobe_n} = CMD_NOP;
      {high_byte_mask, low_byte_mask} = 2'b00;
      dq_in = ~dq_in;
    end
  endtask
endmodule // sdram_ctrl_model

`default_nettype wire

/* dv/sdram_command_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sdram_command_interface_tb;
  import sdram_cmd_pkg::*;
  logic clk, rst_n, gate, sel_n, ras_n, cas_n, we_n, lm, hm;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din, dout;
  logic [1:0] oe;
  logic [ADDR_W-1:0] ext;
  power_state_t pst;
  logic [17:0] exp_q[$];
  int err_count, n_tests;
  logic [DATA_W-1:0] w[4], v[4], e[4];
  logic [1:0] mk[4];
  logic [ROW_W-1:0] row;
  logic [COL_W-1:0] col;
  logic [BANK_W-1:0] bk;

  sdram_ctrl_model m (.clk(clk), .clock_gate_in(gate), .select_n(sel_n),
    .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_strobe_n(we_n),
    .bank_select(ba), .row_column_address(addr), .low_byte_mask(lm),
    .high_byte_mask(hm), .dq_in(din));

  sdram_command_interface DUT (.clk(clk), .rst_n(rst_n), .clock_gate_in(gate),
    .select_n(sel_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
    .write_strobe_n(we_n), .bank_select(ba), .row_column_address(addr),
    .low_byte_mask(lm), .high_byte_mask(hm), .dq_in(din), .dq_out(dout),
    .dq_oe(oe), .ext_mode(ext), .power_state(pst));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_val(input string nm, input logic [11:0] ex, input logic [11:0] got);
    n_tests++;
    if (got !== ex)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Only enabled bytes carry data worth comparing
  task automatic chk_word(input logic [17:0] ex, input logic [17:0] got);
    logic [15:0] bm;
    bm = {{8{ex[17]}}, {8{ex[16]}}};
    n_tests++;
    if (got[17:16] !== ex[17:16] || (got[15:0] & bm) !== (ex[15:0] & bm))
    begin
      err_count++;
      $display("MISMATCH read_word expected %h seen %h", ex, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Each driven word pops the oldest note; an unexpected word is a mismatch
  always @(negedge clk)
    if (rst_n === 1'b1 && oe !== 2'b00)
    begin
      if (exp_q.size() == 0)
        chk_word(18'h0_0000, {oe, dout});
      else
        chk_word(exp_q.pop_front(), {oe, dout});
    end

  // Drop the gate with a code on the bus, check the state, then leave with a NOP
  task automatic gate_test(input power_state_t want, input logic [2:0] code);
    m.idle(2, 1'b1);
    m.gate_cmd(code);
    m.idle(2, 1'b0);
    chk_val("power_state", 12'(want), 12'(pst));
    m.idle(2, 1'b1);
    chk_val("power_state", 12'(PS_RUN), 12'(pst));
  endtask

  initial
  begin
    rst_n = 1'b0;
    err_count = 0;
    n_tests = 0;
    mk = '{2'b00, 2'b01, 2'b10, 2'b11};
    void'($urandom(32'hebf95e7a));
    repeat (6) @(negedge clk);
    chk_val("ext_mode", 12'h000, ext);
    chk_val("power_state", 12'(PS_RUN), 12'(pst));
    rst_n = 1'b1;
    m.idle(2500, 1'b1);
    m.cmd(CMD_LMR, MR_SEL_BASE, 12'h022, 2'b00, 16'h0000);
    m.drop_sel = 1'b1;
    m.cmd(CMD_LMR, MR_SEL_EXT, 12'h5a5, 2'b00, 16'h0000);
    m.drop_sel = 1'b0;
    m.idle(2, 1'b1);
    chk_val("ext_mode", 12'h000, ext);
    m.cmd(CMD_LMR, MR_SEL_EXT, 12'h3c6, 2'b00, 16'h0000);
    m.idle(2, 1'b1);
    chk_val("ext_mode", 12'h3c6, ext);
    bk = 2'($urandom());
    row = 12'($urandom());
    col = {7'($urandom()), 2'b00};
    m.cmd(CMD_ACT, bk, row, 2'b00, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      w[i] = 16'($urandom());
      v[i] = 16'($urandom());
      e[i] = v[i];
      if (mk[i][0])
        e[i][7:0] = w[i][7:0];
      if (mk[i][1])
        e[i][15:8] = w[i][15:8];
    end
    // Second burst follows the first with no gap
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
        m.cmd(i == 0 ? CMD_WR : CMD_NOP, bk, {3'b000, col}, p == 1 ? mk[i] : 2'b00,
              p == 1 ? v[i] : w[i]);
    for (int i = 0; i < 4; i++)
      exp_q.push_back({(i == 1) ? 2'b01 : ((i == 2) ? 2'b10 : 2'b11), e[i]});
    m.cmd(CMD_RD, bk, {3'b000, col}, 2'b00, 16'h0000);
    m.cmd(CMD_NOP, bk, 12'h000, 2'b10, 16'h0000);
    m.cmd(CMD_NOP, bk, 12'h000, 2'b01, 16'h0000);
    m.idle(6, 1'b1);
    // Full page burst cut after two words
    m.cmd(CMD_LMR, MR_SEL_BASE, 12'h027, 2'b00, 16'h0000);
    exp_q.push_back({2'b11, e[0]});
    exp_q.push_back({2'b11, e[1]});
    m.cmd(CMD_RD, bk, {3'b000, col}, 2'b00, 16'h0000);
    m.cmd(CMD_NOP, bk, 12'h000, 2'b00, 16'h0000);
    m.cmd(CMD_BST, bk, 12'h000, 2'b00, 16'h0000);
    m.idle(7, 1'b1);
    // A page write still running when the gate drops suspends, then resumes
    m.cmd(CMD_WR, bk, {3'b000, col + 9'd8}, 2'b00, 16'h0000);
    gate_test(PS_SUSPEND, CMD_NOP);
    m.cmd(CMD_BST, bk, 12'h000, 2'b00, 16'h0000);
    m.cmd(CMD_PRE, bk + 2'h1, 12'h000, 2'b00, 16'h0000);
    gate_test(PS_ACT_PD, CMD_NOP);
    m.cmd(CMD_PRE, 2'h0, 12'h400, 2'b00, 16'h0000);
    gate_test(PS_PRE_PD, CMD_NOP);
    gate_test(PS_SELF_REF, CMD_REF);
    gate_test(PS_DEEP_PD, CMD_BST);
    // Single read with auto precharge must leave every bank idle again
    m.cmd(CMD_ACT, bk, row, 2'b00, 16'h0000);
    m.cmd(CMD_LMR, MR_SEL_BASE, 12'h020, 2'b00, 16'h0000);
    exp_q.push_back({2'b11, e[0]});
    m.cmd(CMD_RD, bk, {3'b010, col}, 2'b00, 16'h0000);
    gate_test(PS_PRE_PD, CMD_NOP);
    for (int t = 0; t < 20 && exp_q.size() != 0; t++)
      @(negedge clk);
    if (exp_q.size() != 0)
    begin
      err_count++;
      $display("MISMATCH pending_words expected 0 seen %0d", exp_q.size());
    end
    give_verdict();
  end
endmodule // sdram_command_interface_tb

`default_nettype wire
